// >>> inc/tmone_pkg.sv
// Behaviour
// - mode 3 halts timer one, count held
// - mode nibble high, control bits 2,3,6,7
// - no gating: run bit alone enables counting
// - gating: ext irq one pin also gates
// - wrap sets timer one overflow flag
// - timer zero mode 3 borrows run/flag
// - mode 0: 5-bit prescaler feeds high byte
// - mode 1: 16-bit cascade counter
// - mode 2: low byte reloads from high
// - vectoring clears overflow flag
// - irq needs local and global enable
// - timer zero overflow sets bit 5
// - run bit 6 turns timer on/off
// - ext irq zero edge flag set/clear
// - control register resets to zero
// - timer ticks every 6 clocks
// - counter counts sampled falling edges
// - gating: count while pin high
package tmone_pkg;
  // register byte addresses on the apb side
  localparam logic [7:0] TMONE_CTRL_OFF  = 8'h88;
  localparam logic [7:0] TMONE_MODE_OFF  = 8'h89;
  localparam logic [7:0] TMONE_LOW_OFF   = 8'h8B;
  localparam logic [7:0] TMONE_HIGH_OFF  = 8'h8D;
  localparam logic [7:0] TMONE_IEN_OFF   = 8'hA8;
  localparam logic [7:0] TMONE_ACK_OFF   = 8'hAC;
  // control register bit positions
  localparam int TMONE_IT0_BIT = 0;
  localparam int TMONE_IE0_BIT = 1;
  localparam int TMONE_IT1_BIT = 2;
  localparam int TMONE_IE1_BIT = 3;
  localparam int TMONE_TR0_BIT = 4;
  localparam int TMONE_TF0_BIT = 5;
  localparam int TMONE_TR1_BIT = 6;
  localparam int TMONE_TF1_BIT = 7;
  // mode register fields for timer one
  localparam int TMONE_GATE_BIT = 7;
  localparam int TMONE_CT_BIT   = 6;
  localparam int TMONE_MHI_BIT  = 5;
  localparam int TMONE_MLO_BIT  = 4;
  // interrupt enable bits
  localparam int TMONE_ET0_BIT = 1;
  localparam int TMONE_ET1_BIT = 3;
  localparam int TMONE_EA_BIT  = 7;
  // vector acknowledge bits
  localparam int TMONE_ACK_T0_BIT  = 0;
  localparam int TMONE_ACK_T1_BIT  = 1;
  localparam int TMONE_ACK_X0_BIT  = 2;
  // reset values
  localparam logic [7:0] TMONE_CTRL_RST = 8'h00;
  localparam logic [7:0] TMONE_BYTE_RST = 8'h00;
  // timing: peripheral cycle is 6 clocks at 4 ns
  localparam int TMONE_CLK_NS      = 4;
  localparam int TMONE_PCYC_NS     = 24;
  localparam int TMONE_PCYC_CLOCKS = (TMONE_PCYC_NS + TMONE_CLK_NS - 1) / TMONE_CLK_NS;
  // timer one modes
  typedef enum logic [1:0] {
    TMONE_M13 = 2'h0,
    TMONE_M16 = 2'h1,
    TMONE_M8R = 2'h2,
    TMONE_MHLT = 2'h3
  } tmone_mode_t;
endpackage

// >>> logic/tmone_pdiv.sv
`timescale 1ns/100ps
// peripheral cycle divider: one-cycle enable every div_count clocks
module tmone_pdiv #(
  parameter int DIV_COUNT = 6
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  output logic      tick_out
);
  initial begin
    if (DIV_COUNT < 2 || DIV_COUNT > 255) begin
      $error("div_count out of range");
    end
  end
  logic [7:0] cnt_reg;   // down counter
  logic [7:0] cnt_next;
  logic       tick_reg;  // registered enable
  logic       tick_next;
  // count down, reload at zero
  always_comb begin
    tick_next = (cnt_reg == 8'h00);
    cnt_next  = tick_next ? 8'(DIV_COUNT - 1) : cnt_reg - 8'h01;
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end
  assign tick_out = tick_reg;
endmodule // tmone_pdiv

// >>> logic/tmone_timer.sv
`timescale 1ns/100ps
// timer one with shared control register, apb slave
module tmone_timer
  import tmone_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        ext_irq_one_pin_in,   // active low irq pin, gating source
  input  wire logic        ext_irq_zero_pin_in,  // active low irq pin
  input  wire logic        timer_one_count_pin_in,
  input  wire logic        t0_overflow_in,       // pulse from timer zero low counter
  input  wire logic        t0_high_overflow_in,  // pulse from timer zero high counter
  input  wire logic        t0_mode3_in,          // timer zero in split mode
  output logic             timer_zero_irq_out,
  output logic             timer_one_irq_out,
  output logic             timer_zero_run_out,
  output logic             t0_high_run_out,      // borrowed run bit
  output logic             timer_one_baud_out    // overflow pulse for serial baud
);
  logic pcyc_tick;  // one peripheral cycle enable
  tmone_pdiv #(.DIV_COUNT(TMONE_PCYC_CLOCKS)) u_pdiv (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .tick_out (pcyc_tick)
  );

  // register state
  logic [7:0] ctrl_reg, ctrl_next;       // timer control register
  logic [7:0] mode_reg, mode_next;       // upper nibble: timer one
  logic [7:0] low_reg, low_next;         // timer one low byte
  logic [7:0] high_reg, high_next;       // timer one high byte
  logic [7:0] ien_reg, ien_next;         // irq enable register zero
  logic       cpin_reg, cpin_next;       // last count pin sample
  logic       x0_reg, x0_next;           // last ext irq zero sample
  logic       baud_reg, baud_next;       // overflow pulse out
  logic [31:0] rdata_reg, rdata_next;    // registered read data

  // bus decode
  logic wr_acc, rd_acc, addr_ok;
  function automatic logic known_addr(input logic [7:0] a);
    return (a == TMONE_CTRL_OFF) || (a == TMONE_MODE_OFF) || (a == TMONE_LOW_OFF) ||
           (a == TMONE_HIGH_OFF) || (a == TMONE_IEN_OFF) || (a == TMONE_ACK_OFF);
  endfunction
  assign addr_ok     = known_addr(paddr_in);
  assign wr_acc      = psel_in && penable_in && pwrite_in;
  assign rd_acc      = psel_in && penable_in && !pwrite_in;
  // zero wait states; unmapped addresses answer with an error
  assign pready_out  = psel_in && penable_in;
  assign pslverr_out = psel_in && penable_in && !addr_ok;

  // decoded timer one controls
  tmone_mode_t mode1;
  logic        run1, gate_ok, count_en, src_step, step;
  logic        wrap, t0_tick_pulse;
  logic [15:0] cas;
  logic [5:0]  pre;
  logic [8:0]  th9, tl9;
  logic [7:0]  ack;
  assign mode1 = tmone_mode_t'(mode_reg[TMONE_MHI_BIT:TMONE_MLO_BIT]);
  assign ack   = (wr_acc && paddr_in == TMONE_ACK_OFF) ? pwdata_in[7:0] : 8'h00;

  // step and counter logic
  always_comb begin
    run1 = ctrl_reg[TMONE_TR1_BIT] && !t0_mode3_in;
    gate_ok  = !mode_reg[TMONE_GATE_BIT] || ext_irq_one_pin_in;
    count_en = run1 && gate_ok;
    src_step = mode_reg[TMONE_CT_BIT] ? (cpin_reg && !timer_one_count_pin_in) : 1'b1;
    step = pcyc_tick && count_en && src_step && (mode1 != TMONE_MHLT);
    cpin_next = pcyc_tick ? timer_one_count_pin_in : cpin_reg;
    low_next  = low_reg;
    high_next = high_reg;
    wrap = 1'b0;
    cas = 16'h0000;
    pre = 6'h00;
    th9 = 9'h000;
    tl9 = 9'h000;
    if (step) begin
      unique case (mode1)
        TMONE_M13: begin
          pre = {1'b0, low_reg[4:0]} + 6'h01;
          low_next = {low_reg[7:5], pre[4:0]};
          if (pre[5]) begin
            th9 = {1'b0, high_reg} + 9'h001;
            high_next = th9[7:0];
            wrap = th9[8];
          end
        end
        TMONE_M16: begin
          cas = {high_reg, low_reg} + 16'h0001;
          low_next = cas[7:0];
          high_next = cas[15:8];
          wrap = (cas == 16'h0000);
        end
        TMONE_M8R: begin
          tl9 = {1'b0, low_reg} + 9'h001;
          low_next = tl9[8] ? high_reg : tl9[7:0];
          wrap = tl9[8];
        end
        TMONE_MHLT: begin
          low_next = low_reg;
        end
      endcase
    end
    if (wr_acc && paddr_in == TMONE_LOW_OFF) begin
      low_next = pwdata_in[7:0];
    end
    if (wr_acc && paddr_in == TMONE_HIGH_OFF) begin
      high_next = pwdata_in[7:0];
    end
    baud_next = wrap;
  end

  // control register: writes, then hardware clears, then hardware sets win
  always_comb begin
    ctrl_next = ctrl_reg;
    mode_next = mode_reg;
    ien_next  = ien_reg;
    x0_next   = ext_irq_zero_pin_in;
    if (wr_acc && paddr_in == TMONE_CTRL_OFF) begin
      ctrl_next = pwdata_in[7:0];
    end
    if (wr_acc && paddr_in == TMONE_MODE_OFF) begin
      mode_next = pwdata_in[7:0];
    end
    if (wr_acc && paddr_in == TMONE_IEN_OFF) begin
      ien_next = pwdata_in[7:0];
    end
    if (ack[TMONE_ACK_T0_BIT]) begin
      ctrl_next[TMONE_TF0_BIT] = 1'b0;
    end
    if (ack[TMONE_ACK_T1_BIT]) begin
      ctrl_next[TMONE_TF1_BIT] = 1'b0;
    end
    // edge flag cleared only if edge mode
    if (ack[TMONE_ACK_X0_BIT] && ctrl_reg[TMONE_IT0_BIT]) begin
      ctrl_next[TMONE_IE0_BIT] = 1'b0;
    end
    if (ctrl_reg[TMONE_IT0_BIT] ? (x0_reg && !ext_irq_zero_pin_in) : !ext_irq_zero_pin_in) begin
      ctrl_next[TMONE_IE0_BIT] = 1'b1;
    end
    if (t0_overflow_in) begin
      ctrl_next[TMONE_TF0_BIT] = 1'b1;
    end
    if (t0_mode3_in ? t0_high_overflow_in : wrap) begin
      ctrl_next[TMONE_TF1_BIT] = 1'b1;
    end
  end

  // read mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_acc) begin
      unique case (paddr_in)
        TMONE_CTRL_OFF: rdata_next = {24'h000000, ctrl_reg};
        TMONE_MODE_OFF: rdata_next = {24'h000000, mode_reg};
        TMONE_LOW_OFF:  rdata_next = {24'h000000, low_reg};
        TMONE_HIGH_OFF: rdata_next = {24'h000000, high_reg};
        TMONE_IEN_OFF:  rdata_next = {24'h000000, ien_reg};
        default:        rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_reg  <= TMONE_CTRL_RST;
      mode_reg  <= TMONE_BYTE_RST;
      low_reg   <= TMONE_BYTE_RST;
      high_reg  <= TMONE_BYTE_RST;
      ien_reg   <= TMONE_BYTE_RST;
      cpin_reg  <= 1'b0;
      x0_reg    <= 1'b1;
      baud_reg  <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg  <= ctrl_next;
      mode_reg  <= mode_next;
      low_reg   <= low_next;
      high_reg  <= high_next;
      ien_reg   <= ien_next;
      cpin_reg  <= cpin_next;
      x0_reg    <= x0_next;
      baud_reg  <= baud_next;
      rdata_reg <= rdata_next;
    end
  end

  // read data is combinational through the access phase so it is valid at pready
  assign prdata_out = rdata_next;
  assign timer_zero_irq_out = ctrl_reg[TMONE_TF0_BIT] && ien_reg[TMONE_ET0_BIT] &&
                              ien_reg[TMONE_EA_BIT];
  assign timer_one_irq_out  = ctrl_reg[TMONE_TF1_BIT] && ien_reg[TMONE_ET1_BIT] &&
                              ien_reg[TMONE_EA_BIT];
  assign timer_zero_run_out = ctrl_reg[TMONE_TR0_BIT];
  assign t0_high_run_out    = ctrl_reg[TMONE_TR1_BIT];
  assign timer_one_baud_out = baud_reg;
  assign t0_tick_pulse      = pcyc_tick;

  // assertions
  property p_halt;
    @(posedge clk_in) disable iff (!rst_b_in)
      (mode1 == TMONE_MHLT && !wr_acc) |=> $stable(low_reg) && $stable(high_reg);
  endproperty
  a_halt: assert property (p_halt) else $error("mode 3 changed count");
  property p_reset_ctrl;
    @(posedge clk_in) $rose(rst_b_in) |-> ctrl_reg == 8'h00;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not zero");
  property p_wrap_flag;
    @(posedge clk_in) disable iff (!rst_b_in)
      (wrap && !t0_mode3_in) |=> ctrl_reg[TMONE_TF1_BIT];
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("overflow flag missed");
  property p_no_run;
    @(posedge clk_in) disable iff (!rst_b_in)
      (!ctrl_reg[TMONE_TR1_BIT] && !wr_acc) |=> $stable({high_reg, low_reg});
  endproperty
  a_no_run: assert property (p_no_run) else $error("counted while stopped");
  property p_gate;
    @(posedge clk_in) disable iff (!rst_b_in)
      (mode_reg[TMONE_GATE_BIT] && !ext_irq_one_pin_in && !wr_acc) |=> $stable(low_reg);
  endproperty
  a_gate: assert property (p_gate) else $error("counted with pin low");
  property p_reload;
    @(posedge clk_in) disable iff (!rst_b_in)
      (step && mode1 == TMONE_M8R && low_reg == 8'hFF && !wr_acc) |=>
        low_reg == $past(high_reg) && $stable(high_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("reload wrong");
  property p_tick_spacing;
    @(posedge clk_in) disable iff (!rst_b_in) t0_tick_pulse |=> !t0_tick_pulse [*5];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick too often");
  property p_irq;
    @(posedge clk_in) disable iff (!rst_b_in)
      timer_one_irq_out |-> ien_reg[TMONE_EA_BIT] && ien_reg[TMONE_ET1_BIT];
  endproperty
  a_irq: assert property (p_irq) else $error("irq without enable");
  property p_ack_clear;
    @(posedge clk_in) disable iff (!rst_b_in)
      (ack[TMONE_ACK_T1_BIT] && !wrap && !t0_mode3_in) |=> !ctrl_reg[TMONE_TF1_BIT];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("flag not cleared");
  property p_wr_wins;
    @(posedge clk_in) disable iff (!rst_b_in)
      (wr_acc && paddr_in == TMONE_LOW_OFF) |=> low_reg == $past(pwdata_in[7:0]);
  endproperty
  a_wr_wins: assert property (p_wr_wins) else $error("write lost");
  c_wrap16: cover property (@(posedge clk_in) wrap && mode1 == TMONE_M16);
  c_wrap13: cover property (@(posedge clk_in) wrap && mode1 == TMONE_M13);
  c_reload: cover property (@(posedge clk_in) wrap && mode1 == TMONE_M8R);
endmodule // tmone_timer

// >>> testbench/tmone_timer_test.sv
`timescale 1ns/100ps
// self-checking bench for timer one, driven straight at its ports
module tmone_timer_test
  import tmone_pkg::*;
();
  logic        clk_in;     // 250 MHz core clock
  logic        rst_b_in;   // async reset, active low
  logic        psel;       // apb select
  logic        penable;    // apb access phase
  logic        pwrite;     // apb direction
  logic [7:0]  paddr;      // apb byte address
  logic [31:0] pwdata;     // apb write data
  logic [31:0] prdata;     // apb read data
  logic        pready;     // apb answer
  logic        pslverr;    // apb refusal
  logic        x1_pin;     // gating pin, high lets timer one run
  logic        x0_pin;     // ext irq zero pin, idle high
  logic        cnt_pin;    // external count input
  logic        t0_ovf;     // timer zero overflow pulse
  logic        t0_hovf;    // timer zero high byte overflow pulse
  logic        t0_m3;      // timer zero split mode
  logic        irq0;       // timer zero request
  logic        irq1;       // timer one request
  logic        run0;       // timer zero run bit
  logic        hrun;       // borrowed run bit
  logic        baud;       // timer one wrap pulse
  logic [31:0] rd_q;       // last read data
  logic        err_q;      // last pslverr
  int          err_count;  // mismatches
  int          n_checks;   // comparisons
  int          cyc;        // cycles run, for the hang guard
  int          baud_cnt;   // wrap pulses seen

  tmone_timer u_tmone_timer (
    .clk_in                 (clk_in),
    .rst_b_in               (rst_b_in),
    .psel_in                (psel),
    .penable_in             (penable),
    .pwrite_in              (pwrite),
    .paddr_in               (paddr),
    .pwdata_in              (pwdata),
    .prdata_out             (prdata),
    .pready_out             (pready),
    .pslverr_out            (pslverr),
    .ext_irq_one_pin_in     (x1_pin),
    .ext_irq_zero_pin_in    (x0_pin),
    .timer_one_count_pin_in (cnt_pin),
    .t0_overflow_in         (t0_ovf),
    .t0_high_overflow_in    (t0_hovf),
    .t0_mode3_in            (t0_m3),
    .timer_zero_irq_out     (irq0),
    .timer_one_irq_out      (irq1),
    .timer_zero_run_out     (run0),
    .t0_high_run_out        (hrun),
    .timer_one_baud_out     (baud)
  );

  // free-running clock, 4 ns period
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // hang guard and wrap pulse counter; ceiling far above the fewer than a thousand cycles needed
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (baud === 1'b1) begin
      baud_cnt <= baud_cnt + 1;
    end
    if (cyc == 20000) begin
      err_count = err_count + 1;
      results();
    end
  end

  // compare and count; x never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // one apb transfer, entered just after a rising edge; one idle cycle after
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk_in);
    penable <= 1'b1;
    // wait for pready as long as it takes; only the hang guard ends a dead wait
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    rd_q  = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(rd_q, {24'h000000, exp});
  endtask

  // load counts while halted; mode 3 as the off switch so the run bit can stay set
  // mode 3 as switch
  task automatic prep(input logic [7:0] lo, input logic [7:0] hi);
    wr(TMONE_MODE_OFF, 8'h30);
    wr(TMONE_LOW_OFF, lo);
    wr(TMONE_HIGH_OFF, hi);
    wr(TMONE_CTRL_OFF, 8'h40);
  endtask

  // count for exactly 60 clocks (ten peripheral ticks) between the two landing edges
  task automatic go(input logic [7:0] md);
    wr(TMONE_MODE_OFF, md);
    repeat (57) @(posedge clk_in);
    wr(TMONE_MODE_OFF, md | 8'h30);
  endtask

  task automatic t_reset_and_bus();
    rdc(TMONE_CTRL_OFF, TMONE_CTRL_RST);
    rdc(TMONE_LOW_OFF, TMONE_BYTE_RST);
    xfer(1'b1, 8'h90, 8'hFF);
    xfer(1'b0, 8'h90, 8'h00);
    chk({rd_q[7:0], 7'h00, err_q}, 16'h0001);
  endtask

  task automatic t_run_bit();
    wr(TMONE_MODE_OFF, 8'h10);
    wr(TMONE_LOW_OFF, 8'hF8);
    wr(TMONE_HIGH_OFF, 8'h12);
    wr(TMONE_CTRL_OFF, 8'h40);
    repeat (57) @(posedge clk_in);
    wr(TMONE_CTRL_OFF, 8'h00);
    // stays put once the run bit is gone
    repeat (12) @(posedge clk_in);
    rdc(TMONE_LOW_OFF, 8'h02);
    rdc(TMONE_HIGH_OFF, 8'h13);
  endtask

  task automatic t_wrap_irq();
    wr(TMONE_IEN_OFF, 8'h88);
    prep(8'hFC, 8'hFF);
    go(8'h10);
    rdc(TMONE_LOW_OFF, 8'h06);
    rdc(TMONE_CTRL_OFF, 8'hC0);
    chk(irq1, 1'b1);
    wr(TMONE_IEN_OFF, 8'h08);
    chk(irq1, 1'b0);
    wr(TMONE_ACK_OFF, 8'h02);
    rdc(TMONE_CTRL_OFF, 8'h40);
  endtask

  task automatic t_modes();
    // mode 0: five-bit prescaler carries once into the high byte
    prep(8'hFE, 8'h05);
    go(8'h00);
    rdc(TMONE_LOW_OFF, 8'hE8);
    rdc(TMONE_HIGH_OFF, 8'h06);
    // mode 2: wraps on the fourth tick, reloads, then six more ticks
    // baud-style mode 2
    prep(8'hFC, 8'hA0);
    go(8'h20);
    rdc(TMONE_LOW_OFF, 8'hA6);
    rdc(TMONE_HIGH_OFF, 8'hA0);
    rdc(TMONE_CTRL_OFF, 8'hC0);
    // mode 3 holds the count
    prep(8'h11, 8'h22);
    go(8'h30);
    rdc(TMONE_LOW_OFF, 8'h11);
  endtask

  task automatic t_gate_borrow();
    x1_pin <= 1'b0;
    prep(8'h00, 8'h00);
    go(8'h90);
    rdc(TMONE_LOW_OFF, 8'h00);
    x1_pin <= 1'b1;
    prep(8'h00, 8'h00);
    go(8'h90);
    rdc(TMONE_LOW_OFF, 8'h0A);
    t0_m3 <= 1'b1;
    prep(8'h00, 8'h00);
    go(8'h10);
    rdc(TMONE_LOW_OFF, 8'h00);
    chk(hrun, 1'b1);
    t0_hovf <= 1'b1;
    @(posedge clk_in);
    t0_hovf <= 1'b0;
    @(posedge clk_in);
    rdc(TMONE_CTRL_OFF, 8'hC0);
    t0_m3 <= 1'b0;
  endtask

  task automatic t_counter();
    prep(8'h00, 8'h00);
    wr(TMONE_MODE_OFF, 8'h50);
    // each level held two peripheral cycles so both samples see it
    repeat (3) begin
      repeat (12) @(posedge clk_in);
      cnt_pin <= 1'b0;
      repeat (12) @(posedge clk_in);
      cnt_pin <= 1'b1;
    end
    repeat (12) @(posedge clk_in);
    wr(TMONE_MODE_OFF, 8'h70);
    rdc(TMONE_LOW_OFF, 8'h03);
  endtask

  task automatic t_zero_side();
    wr(TMONE_CTRL_OFF, 8'h10);
    wr(TMONE_IEN_OFF, 8'h82);
    chk(run0, 1'b1);
    t0_ovf <= 1'b1;
    @(posedge clk_in);
    t0_ovf <= 1'b0;
    @(posedge clk_in);
    rdc(TMONE_CTRL_OFF, 8'h30);
    chk(irq0, 1'b1);
    wr(TMONE_ACK_OFF, 8'h01);
    rdc(TMONE_CTRL_OFF, 8'h10);
    // edge-triggered ext irq zero
    wr(TMONE_CTRL_OFF, 8'h01);
    x0_pin <= 1'b0;
    repeat (3) @(posedge clk_in);
    x0_pin <= 1'b1;
    @(posedge clk_in);
    rdc(TMONE_CTRL_OFF, 8'h03);
    wr(TMONE_ACK_OFF, 8'h04);
    rdc(TMONE_CTRL_OFF, 8'h01);
  endtask

  // verdict, the single exit point
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    err_count = 0;
    n_checks  = 0;
    cyc       = 0;
    baud_cnt  = 0;
    rst_b_in  = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {x1_pin, x0_pin, cnt_pin} = 3'h7;
    {t0_ovf, t0_hovf, t0_m3} = 3'h0;
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    t_reset_and_bus();
    t_run_bit();
    t_wrap_irq();
    t_modes();
    t_gate_borrow();
    t_counter();
    t_zero_side();
    chk(baud_cnt, 32'h2);
    results();
  end
endmodule // tmone_timer_test
